// ===== lwm_top.sv
/*
 lwm mode, wake-up and reset sequencer of a lin transceiver.
 assumes synchronous pin inputs and analog comparators given as levels.
*/
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
// Operation
// - sleep leaves to standby on remote/local wake
// - power-on or undervoltage passes init, then standby
// - remote wake: fall, long dominant, rise; rxd low
// - switch wake: fall then low past filter
// - ignition high over 250 us wakes to standby
// - ignition rearms after low over 250 us
// - ignition level ignores enable mode switching
// - local wake flag shown low on txd
// - enable high clears wake request and flag
// - reset delay starts when supplies good
// - vcc dropout asserts reset only after filter
// - watchdog starts at reset release, drives reset in normal
// - over-temperature forces standby, transmit and wake detection off
// - thermal recovery: standby, normal if enable high
// - standby timeout cleared during thermal shutdown
// - battery undervoltage forces init then standby
// - enable high at power-up gives normal
// - regulator off during battery undervoltage
// - transmit blocked sleep, silent, thermal, reset
// - bus level debounced onto rxd
// - slew output normal or low setting
// - basic variant: remote wake only, no flag
// - first enable rise latches slew from txd
// - standby times out to sleep after 350 ms
// - enable fall: txd high silent, low sleep
// - reset delay lasts 4 ms
`timescale 1ns/1ps
`default_nettype none
`include "lwm_regs.svh"
module lwm_top #(
    parameter int TICK_CYC = `LWM_TICK_CYC,
    parameter int BUS_WAKE_TK = `LWM_TK(`LWM_BUS_WAKE_US),
    parameter int SW_WAKE_TK = `LWM_TK(`LWM_SW_WAKE_US),
    parameter int IGN_WAKE_TK = `LWM_TK(`LWM_IGN_WAKE_US),
    parameter int RES_DELAY_TK = `LWM_TK(`LWM_RES_DELAY_US),
    parameter int RR_FILT_TK = `LWM_TK(`LWM_RR_FILT_US),
    parameter int STBY_TO_TK = `LWM_TK(`LWM_STBY_TO_US),
    parameter int DEB_TK = `LWM_TK(`LWM_DEB_US)
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // avalon-mm slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire lwm_pkg::lwm_word_t AVS_WRITEDATA,
    output lwm_pkg::lwm_word_t AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // host pins
    input wire logic EN,
    input wire logic TXD_IN,
    output logic TXD_OUT,
    output logic TXD_OE,
    output logic RXD_OUT,
    output logic RESET_OUTPUT_N,
    input wire logic WD_OK,
    output logic WD_RUN,
    // bus and local wake
    input wire logic LIN_IN,
    output logic LIN_DRV_DOM,
    output logic SLEW_LOW,
    input wire logic SWITCH_WAKE_N,
    input wire logic IGNITION_SENSE_INPUT,
    // supply and thermal
    input wire logic BATTERY_LOW,
    input wire logic VCC_OK,
    input wire logic THERMAL_SHUTDOWN,
    output logic REG_ON
);
    import lwm_pkg::*;

    lwm_state_e state_q;
    lwm_state_e state_d;
    logic [11:0] div_q;
    logic tick_q;
    logic en_q;
    logic lin_q;
    logic sw_q;
    logic ign_q;
    logic bus_arm_q;
    logic sw_arm_q;
    logic ign_arm_q;
    logic ign_lock_q;
    logic tsd_q;
    logic pend_q;
    logic rst_n_q;
    logic tx_en_q;
    logic slew_set_q;
    logic slew_low_q;
    logic rxd_bus_q;
    logic wake_req_q;
    logic wake_src_q;
    logic [1:0] cfg_q;
    logic en_rise;
    logic en_fall;
    logic lin_fall;
    logic lin_rise;
    logic sw_fall;
    logic ign_rise;
    logic listen;
    logic loc_ok;
    logic wake_rem;
    logic wake_loc;
    logic wake_any;

    lwm_reg_if rg ();
    lwm_flt_if fi[F_NUM] ();

    // ==========================================
    // register slave
    assign rg.address = AVS_ADDRESS;
    assign rg.byteenable = AVS_BYTEENABLE;
    assign rg.read = AVS_READ;
    assign rg.write = AVS_WRITE;
    assign rg.writedata = AVS_WRITEDATA;
    assign rg.status = {tsd_q, rst_n_q, slew_low_q, wake_src_q, wake_req_q, state_q};
    assign AVS_READDATA = rg.readdata;
    assign AVS_WAITREQUEST = rg.waitrequest;

    lwm_avs u_avs (
        .clk(REF_CLK),
        .rst(RESET),
        .rg(rg)
    );

    // ==========================================
    // oscillator tick and filter timers
    always_ff @(posedge REF_CLK)
    begin
        if (RESET || div_q == 12'(TICK_CYC - 1))
            div_q <= '0;
        else
            div_q <= div_q + 12'h001;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            tick_q <= 1'b0;
        else
            tick_q <= div_q == 12'(TICK_CYC - 1);
    end

    for (genvar g = 0; g < F_NUM; g++)
    begin : g_flt
        assign fi[g].tick = tick_q;
        lwm_filt u_flt (
            .clk(REF_CLK),
            .rst(RESET),
            .f(fi[g])
        );
    end

    assign fi[F_BUS].limit = lwm_cnt_t'(BUS_WAKE_TK);
    assign fi[F_SW].limit = lwm_cnt_t'(SW_WAKE_TK);
    assign fi[F_IGN].limit = lwm_cnt_t'(IGN_WAKE_TK);
    assign fi[F_IGNL].limit = lwm_cnt_t'(IGN_WAKE_TK);
    assign fi[F_POR].limit = lwm_cnt_t'(RES_DELAY_TK);
    assign fi[F_RRF].limit = lwm_cnt_t'(RR_FILT_TK);
    assign fi[F_STBY].limit = lwm_cnt_t'(STBY_TO_TK);
    assign fi[F_DEB].limit = lwm_cnt_t'(DEB_TK);

    assign fi[F_BUS].act = bus_arm_q && !LIN_IN && listen;
    assign fi[F_SW].act = sw_arm_q && !SWITCH_WAKE_N && loc_ok;
    assign fi[F_IGN].act = ign_arm_q && IGNITION_SENSE_INPUT && loc_ok;
    assign fi[F_IGNL].act = ign_lock_q && !IGNITION_SENSE_INPUT;
    assign fi[F_POR].act = !rst_n_q && VCC_OK && REG_ON && !BATTERY_LOW;
    assign fi[F_RRF].act = rst_n_q && !VCC_OK;
    assign fi[F_STBY].act = state_q == ST_STANDBY && !tsd_q && !EN;
    assign fi[F_DEB].act = LIN_IN != rxd_bus_q;

    // ==========================================
    // edges and wake detection
    assign en_rise = EN && !en_q;
    assign en_fall = !EN && en_q;
    assign lin_fall = !LIN_IN && lin_q;
    assign lin_rise = LIN_IN && !lin_q;
    assign sw_fall = !SWITCH_WAKE_N && sw_q;
    assign ign_rise = IGNITION_SENSE_INPUT && !ign_q;
    assign listen = (state_q == ST_SLEEP || state_q == ST_SILENT) && !tsd_q;
    assign loc_ok = listen && cfg_q[`LWM_CTRL_LOCAL];
    assign wake_rem = listen && fi[F_BUS].held && lin_rise;
    assign wake_loc = loc_ok && (fi[F_SW].held || fi[F_IGN].held);
    assign wake_any = wake_rem || wake_loc;

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            en_q <= 1'b0;
            lin_q <= 1'b1;
            sw_q <= 1'b1;
            ign_q <= 1'b0;
            tsd_q <= 1'b0;
        end
        else
        begin
            en_q <= EN;
            lin_q <= LIN_IN;
            sw_q <= SWITCH_WAKE_N;
            ign_q <= IGNITION_SENSE_INPUT;
            tsd_q <= THERMAL_SHUTDOWN;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET || !listen || lin_rise)
            bus_arm_q <= 1'b0;
        else if (lin_fall)
            bus_arm_q <= 1'b1;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET || !loc_ok || SWITCH_WAKE_N)
            sw_arm_q <= 1'b0;
        else if (sw_fall)
            sw_arm_q <= 1'b1;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET || !IGNITION_SENSE_INPUT || ign_lock_q)
            ign_arm_q <= 1'b0;
        else if (ign_rise)
            ign_arm_q <= 1'b1;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            ign_lock_q <= 1'b0;
        else if (fi[F_IGN].held && loc_ok)
            ign_lock_q <= 1'b1;
        else if (fi[F_IGNL].held)
            ign_lock_q <= 1'b0;
    end

    // ==========================================
    // mode state machine
    always_comb
    begin
        state_d = state_q;
        if (BATTERY_LOW)
            state_d = ST_INIT;
        else if (tsd_q)
            state_d = ST_STANDBY;
        else
        begin
            case (state_q)
                ST_INIT:
                    if (REG_ON)
                        state_d = ST_STANDBY;
                ST_STANDBY:
                    // ignition level plays no part here
                    if (rst_n_q && EN && (en_rise || pend_q))
                        state_d = ST_NORMAL;
                    else if (fi[F_STBY].held)
                        state_d = ST_SLEEP;
                ST_NORMAL:
                    if (!rst_n_q)
                        state_d = ST_STANDBY;
                    else if (en_fall)
                        state_d = TXD_IN ? ST_SILENT : ST_SLEEP;
                ST_SILENT:
                    if (!rst_n_q || wake_any)
                        state_d = ST_STANDBY;
                    else if (en_rise)
                        state_d = ST_NORMAL;
                ST_SLEEP:
                    if (wake_any || EN)
                        state_d = ST_STANDBY;
                default:
                    state_d = ST_INIT;
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            state_q <= ST_INIT;
        else
            state_q <= state_d;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            pend_q <= 1'b0;
        else
            pend_q <= state_q == ST_INIT || tsd_q || (state_q == ST_SLEEP && EN) ||
                (state_q == ST_STANDBY && (pend_q || en_rise));
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            cfg_q <= `LWM_CTRL_RST;
        else if (state_q == ST_INIT && !BATTERY_LOW)
            cfg_q <= rg.ctrl;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            REG_ON <= 1'b0;
        else
            REG_ON <= !BATTERY_LOW && state_q != ST_SLEEP;
    end

    // ==========================================
    // reset output and watchdog gate
    always_ff @(posedge REF_CLK)
    begin
        if (RESET || state_q == ST_INIT || BATTERY_LOW || fi[F_RRF].held)
            rst_n_q <= 1'b0;
        else if (fi[F_POR].held)
            rst_n_q <= 1'b1;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            RESET_OUTPUT_N <= 1'b0;
            WD_RUN <= 1'b0;
        end
        else
        begin
            RESET_OUTPUT_N <= rst_n_q && !(cfg_q[`LWM_CTRL_WDOG] &&
                state_q == ST_NORMAL && !WD_OK);
            WD_RUN <= cfg_q[`LWM_CTRL_WDOG] && rst_n_q &&
                (state_q == ST_STANDBY || state_q == ST_NORMAL);
        end
    end

    // ==========================================
    // wake request and source flags
    always_ff @(posedge REF_CLK)
    begin
        if (RESET || state_q == ST_INIT)
        begin
            wake_req_q <= 1'b0;
            wake_src_q <= 1'b0;
        end
        else
        begin
            if (EN)
            begin
                wake_req_q <= 1'b0;
                wake_src_q <= 1'b0;
            end
            if (wake_any)
                wake_req_q <= 1'b1;
            if (wake_loc)
                wake_src_q <= 1'b1;
        end
    end

    // ==========================================
    // transceiver paths and slew
    always_ff @(posedge REF_CLK)
    begin
        if (RESET || state_q != ST_NORMAL)
            tx_en_q <= 1'b0;
        else if (TXD_IN)
            tx_en_q <= 1'b1;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            rxd_bus_q <= 1'b1;
        else if (fi[F_DEB].held)
            rxd_bus_q <= LIN_IN;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET || state_q == ST_INIT)
        begin
            slew_set_q <= 1'b0;
            slew_low_q <= 1'b0;
        end
        else if (en_rise && !slew_set_q)
        begin
            slew_set_q <= 1'b1;
            slew_low_q <= !TXD_IN;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            LIN_DRV_DOM <= 1'b0;
            RXD_OUT <= 1'b1;
            TXD_OE <= 1'b0;
            SLEW_LOW <= 1'b0;
            TXD_OUT <= 1'b0;
        end
        else
        begin
            LIN_DRV_DOM <= state_q == ST_NORMAL && tx_en_q && !tsd_q && rst_n_q &&
                !TXD_IN;
            case (state_q)
                ST_NORMAL: RXD_OUT <= rxd_bus_q;
                ST_STANDBY: RXD_OUT <= !wake_req_q;
                ST_SILENT: RXD_OUT <= 1'b1;
                default: RXD_OUT <= 1'b0;
            endcase
            TXD_OE <= state_q == ST_STANDBY && wake_src_q;
            SLEW_LOW <= slew_low_q;
            TXD_OUT <= 1'b0;
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    sequence s_bus_wake;
        state_q == ST_SLEEP && !BATTERY_LOW && !tsd_q && fi[F_BUS].held && lin_rise;
    endsequence

    a_bus_wake_stby: assert property (s_bus_wake |=> state_q == ST_STANDBY ##1 !RXD_OUT)
        else $error("bus wake did not reach standby with rxd low");
    a_batt_init: assert property (BATTERY_LOW |=> state_q == ST_INIT && !REG_ON)
        else $error("battery low did not force init");
    a_tsd_standby: assert property (tsd_q && !BATTERY_LOW |=> state_q == ST_STANDBY)
        else $error("thermal shutdown did not force standby");
    a_tsd_no_tmo: assert property (tsd_q |-> !fi[F_STBY].act && !fi[F_BUS].act)
        else $error("timers run during thermal shutdown");
    a_tx_block: assert property (LIN_DRV_DOM |-> $past(state_q == ST_NORMAL && rst_n_q))
        else $error("transmit outside normal");
    a_wake_clear: assert property (EN && !wake_any |=> !wake_req_q && !wake_src_q)
        else $error("enable did not clear wake flags");
    a_basic_no_src: assert property (!cfg_q[`LWM_CTRL_LOCAL] && !wake_src_q |=> !wake_src_q)
        else $error("wake source flag in basic variant");
    a_ign_lock_set: assert property (fi[F_IGN].held && loc_ok |=> ign_lock_q ##1 !ign_arm_q)
        else $error("ignition wake did not lock");
    a_rst_filter: assert property ($fell(rst_n_q) |-> $past(fi[F_RRF].held ||
        state_q == ST_INIT || BATTERY_LOW))
        else $error("reset asserted without filter");
    a_en_fall_mode: assert property (state_q == ST_NORMAL && en_fall && rst_n_q && !tsd_q &&
        !BATTERY_LOW |=> state_q == ($past(TXD_IN) ? ST_SILENT : ST_SLEEP))
        else $error("enable fall chose wrong mode");
endmodule
`default_nettype wire

// ===== lwm_regs.svh
/*
 lwm register offsets, field positions, reset values and timing counts.
 assumes a 250 MHz REF_CLK and a 1 us internal oscillator tick.
*/
`ifndef LWM_REGS_SVH
`define LWM_REGS_SVH

// ==========================================
// register map (word index = address[3:2])
`define LWM_ADDR_CTRL 2'h0
`define LWM_ADDR_STAT 2'h1
`define LWM_CTRL_RST 2'h3
`define LWM_CTRL_LOCAL 0
`define LWM_CTRL_WDOG 1
`define LWM_ST_MODE 2:0
`define LWM_ST_WREQ 3
`define LWM_ST_WSRC 4
`define LWM_ST_SLEW 5
`define LWM_ST_RSTN 6
`define LWM_ST_TSD 7

// ==========================================
// timing
`define LWM_CLK_NS 4
`define LWM_TICK_NS 1000
`define LWM_TICK_CYC (`LWM_TICK_NS / `LWM_CLK_NS)
`define LWM_TK(us) ((((us) * 1000) + `LWM_TICK_NS - 1) / `LWM_TICK_NS)
`define LWM_BUS_WAKE_US 150
`define LWM_SW_WAKE_US 50
`define LWM_IGN_WAKE_US 250
`define LWM_RES_DELAY_US 4000
`define LWM_RR_FILT_US 10
`define LWM_STBY_TO_US 350000
`define LWM_DEB_US 1

`endif

// ===== lwm_pkg.sv
/*
 lwm shared types: mode states, filter indices, data words.
 assumes nothing of its surroundings.
*/
`default_nettype none
package lwm_pkg;
    typedef logic [31:0] lwm_word_t;
    typedef logic [19:0] lwm_cnt_t;
    typedef enum logic [2:0] {ST_INIT, ST_STANDBY, ST_NORMAL, ST_SILENT, ST_SLEEP} lwm_state_e;
    typedef enum int {F_BUS, F_SW, F_IGN, F_IGNL, F_POR, F_RRF, F_STBY, F_DEB, F_NUM} lwm_flt_e;
endpackage
`default_nettype wire

// ===== lwm_if.sv
/*
 lwm carriers: filter timer channel and register slave channel.
 assumes lwm_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
interface lwm_flt_if;
    logic tick;
    logic act;
    lwm_pkg::lwm_cnt_t limit;
    logic held;
    modport core (output tick, output act, output limit, input held);
    modport flt (input tick, input act, input limit, output held);
endinterface

interface lwm_reg_if;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic read;
    logic write;
    lwm_pkg::lwm_word_t writedata;
    lwm_pkg::lwm_word_t readdata;
    logic waitrequest;
    logic [1:0] ctrl;
    logic [7:0] status;
    modport core (output address, output byteenable, output read, output write,
        output writedata, output status, input readdata, input waitrequest, input ctrl);
    modport slv (input address, input byteenable, input read, input write,
        input writedata, input status, output readdata, output waitrequest, output ctrl);
endinterface
`default_nettype wire

// ===== lwm_filt.sv
/*
 lwm filter timer: counts oscillator ticks while act is high.
 assumes act drops to restart the count on every qualifying edge.
*/
`timescale 1ns/1ps
`default_nettype none
module lwm_filt (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // channel
    lwm_flt_if.flt f
);
    import lwm_pkg::*;
    lwm_cnt_t cnt_q;
    logic held_q;

    // ==========================================
    // tick counter
    always_ff @(posedge clk)
    begin
        if (rst || !f.act)
            cnt_q <= '0;
        else if (f.tick && cnt_q != f.limit)
            cnt_q <= cnt_q + lwm_cnt_t'(1);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            held_q <= 1'b0;
        else
            held_q <= f.act && cnt_q == f.limit;
    end

    assign f.held = held_q;
endmodule
`default_nettype wire

// ===== lwm_avs.sv
/*
 lwm avalon-mm register slave with one wait state.
 assumes a master that holds its request until waitrequest is low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lwm_regs.svh"
module lwm_avs (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // channel
    lwm_reg_if.slv rg
);
    import lwm_pkg::*;
    logic wait_q;
    logic [1:0] ctrl_q;
    lwm_word_t rdata_q;
    logic [1:0] idx;

    assign idx = rg.address[3:2];

    // ==========================================
    // handshake
    always_ff @(posedge clk)
    begin
        if (rst)
            wait_q <= 1'b1;
        else
            wait_q <= !((rg.read || rg.write) && wait_q);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_q <= '0;
        else if (rg.read && wait_q)
        begin
            case (idx)
                `LWM_ADDR_CTRL: rdata_q <= lwm_word_t'(ctrl_q);
                `LWM_ADDR_STAT: rdata_q <= lwm_word_t'(rg.status);
                default: rdata_q <= '0;
            endcase
        end
    end

    // ==========================================
    // control register
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl_q <= `LWM_CTRL_RST;
        else if (rg.write && !wait_q && idx == `LWM_ADDR_CTRL && rg.byteenable[0])
            ctrl_q <= rg.writedata[1:0];
    end

    assign rg.readdata = rdata_q;
    assign rg.waitrequest = wait_q;
    assign rg.ctrl = ctrl_q;
endmodule
`default_nettype wire

// ===== lwm_bus_node.sv
/*
 lwm far side: lin bus wire and host transmit pin.
 assumes pull-ups on both wires, no other bus node driving.
*/
`timescale 1ns/1ps
`default_nettype none
module lwm_bus_node (
    // device side
    input wire logic lin_drv_dom,
    input wire logic txd_oe,
    // remote node and host
    input wire logic node_dom,
    input wire logic host_txd,
    // resolved wires
    output logic lin_lvl,
    output logic txd_lvl
);
    // ==========================================
    // wired-and with pull-ups
    assign lin_lvl = !(lin_drv_dom || node_dom);
    assign txd_lvl = host_txd && !txd_oe;
endmodule
`default_nettype wire

// ===== lin_wake_mode_controller_test.sv
/*
 lwm self-checking bench: mode, wake, reset and transmit sequences.
 assumes lwm_pkg, lwm_top and lwm_bus_node compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module lin_wake_mode_controller_test;
    import lwm_pkg::*;
    localparam int TK = 4, WK = 3, RD = 5, RF = 2, SB = 60;
    typedef struct {bit pin; lwm_word_t e; lwm_word_t m;} lwm_note_s;
    logic REF_CLK = 0, RESET = 1, AVS_READ = 0, AVS_WRITE = 0, EN = 0, host_txd = 1;
    logic node_dom = 0, SWITCH_WAKE_N = 1, IGNITION_SENSE_INPUT = 0, BATTERY_LOW = 0;
    logic VCC_OK = 1, THERMAL_SHUTDOWN = 0, pin_req = 0, WD_OK = 1;
    logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hF;
    lwm_word_t AVS_WRITEDATA = 32'h0, AVS_READDATA, d, d2;
    logic AVS_WAITREQUEST, TXD_OUT, TXD_OE, RXD_OUT, RESET_OUTPUT_N, WD_RUN, LIN_DRV_DOM;
    logic SLEW_LOW, REG_ON, LIN_IN, TXD_IN;
    logic [31:0] rng = 32'h00013019;
    lwm_note_s notes[$];
    lwm_note_s n;
    int error_cnt = 0, tests_run = 0, k;
    wire [6:0] pins = {RXD_OUT, TXD_OE, LIN_DRV_DOM, RESET_OUTPUT_N, REG_ON, WD_RUN, SLEW_LOW};

    // ==========================================
    // design and far side
    lwm_top #(.TICK_CYC(TK), .BUS_WAKE_TK(WK), .SW_WAKE_TK(WK), .IGN_WAKE_TK(WK),
        .RES_DELAY_TK(RD), .RR_FILT_TK(RF), .STBY_TO_TK(SB)) dut (
        .REF_CLK(REF_CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .EN(EN), .TXD_IN(TXD_IN), .TXD_OUT(TXD_OUT),
        .TXD_OE(TXD_OE), .RXD_OUT(RXD_OUT), .RESET_OUTPUT_N(RESET_OUTPUT_N),
        .WD_OK(WD_OK), .WD_RUN(WD_RUN), .LIN_IN(LIN_IN), .LIN_DRV_DOM(LIN_DRV_DOM),
        .SLEW_LOW(SLEW_LOW), .SWITCH_WAKE_N(SWITCH_WAKE_N),
        .IGNITION_SENSE_INPUT(IGNITION_SENSE_INPUT), .BATTERY_LOW(BATTERY_LOW),
        .VCC_OK(VCC_OK), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .REG_ON(REG_ON));
    lwm_bus_node far (.lin_drv_dom(LIN_DRV_DOM), .txd_oe(TXD_OE), .node_dom(node_dom),
        .host_txd(host_txd), .lin_lvl(LIN_IN), .txd_lvl(TXD_IN));

    // ==========================================
    // helpers
    initial forever #2 REF_CLK = ~REF_CLK;
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic hold(input int c);
        repeat (c) @(posedge REF_CLK);
    endtask
    task automatic avs(input bit wr, input logic [3:0] a, input lwm_word_t w, e, m);
        @(posedge REF_CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= w;
        AVS_READ <= !wr;
        AVS_WRITE <= wr;
        if (!wr)
            notes.push_back('{1'b0, e, m});
        do
            @(posedge REF_CLK);
        while (AVS_WAITREQUEST !== 1'b0);
        d = AVS_READDATA;
        AVS_READ <= 0;
        AVS_WRITE <= 0;
    endtask
    task automatic pin_chk(input logic [6:0] e, m);
        @(posedge REF_CLK);
        notes.push_back('{1'b1, 32'(e), 32'(m)});
        pin_req <= 1;
        @(posedge REF_CLK);
        pin_req <= 0;
    endtask
    task automatic mode(input logic [2:0] s);
        int c;
        c = 0;
        do
        begin
            avs(0, 4'h4, 0, 0, 0);
            c++;
        end
        while (d[2:0] !== s && c < 300);
        avs(0, 4'h4, 0, 32'(s), 32'h7);
    endtask
    task automatic give_verdict();
        $display("counts: %0d checks, %0d mismatches", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================
    // result watcher
    always @(posedge REF_CLK)
    begin
        if ((pin_req || (AVS_READ && AVS_WAITREQUEST === 1'b0)) && notes.size() > 0)
        begin
            n = notes.pop_front();
            d2 = n.pin ? 32'(pins) : AVS_READDATA;
            if (n.m != 0)
            begin
                tests_run++;
                if ((d2 & n.m) !== n.e)
                begin
                    error_cnt++;
                    $display("MISMATCH %s expected %h seen %h", n.pin ? "pins" : "readdata",
                        n.e, d2 & n.m);
                end
            end
        end
    end

    // ==========================================
    // watchdog
    initial
    begin
        #200000;
        error_cnt++;
        give_verdict();
    end

    // ==========================================
    // main sequence
    initial
    begin
        hold(5);
        RESET <= 0;
        avs(0, 4'h0, 0, 32'h3, 32'hFF);
        avs(1, 4'hC, 32'hFFFFFFFF, 0, 0);
        avs(0, 4'hC, 0, 0, 32'hFFFFFFFF);
        avs(1, 4'h4, 32'h7, 0, 0);
        $display("test registers done");
        mode(1);
        for (k = 0; k < 200 && RESET_OUTPUT_N !== 1'b1; k++) @(posedge REF_CLK);
        VCC_OK <= 0;
        hold(1);
        VCC_OK <= 1;
        hold(2 * TK);
        pin_chk(7'h0C, 7'h0C);
        VCC_OK <= 0;
        hold(4 * TK);
        pin_chk(7'h00, 7'h08);
        VCC_OK <= 1;
        for (k = 0; k < 200 && RESET_OUTPUT_N !== 1'b1; k++) @(posedge REF_CLK);
        tests_run++;
        if (k < 4 * TK || k > 6 * TK + 4)
        begin
            error_cnt++;
            $display("MISMATCH reset delay expected %0d seen %0d", 5 * TK, k);
        end
        $display("test reset output done");
        mode(4);
        pin_chk(7'h00, 7'h54);
        node_dom <= 1;
        hold(TK);
        node_dom <= 0;
        hold(6 * TK);
        avs(0, 4'h4, 0, 32'h4, 32'h7);
        node_dom <= 1;
        hold(5 * TK);
        node_dom <= 0;
        mode(1);
        pin_chk(7'h00, 7'h60);
        EN <= 1;
        mode(2);
        pin_chk(7'h40, 7'h61);
        $display("test remote wake done");
        for (k = 0; k < 8; k++)
        begin
            rng = xs(rng);
            host_txd <= rng[0];
            hold(3);
            pin_chk({2'h0, !rng[0], 4'h0}, 7'h10);
        end
        host_txd <= 0;
        hold(3 * TK);
        pin_chk(7'h00, 7'h40);
        host_txd <= 1;
        hold(3 * TK);
        EN <= 0;
        mode(3);
        host_txd <= 0;
        hold(3);
        pin_chk(7'h00, 7'h10);
        host_txd <= 1;
        SWITCH_WAKE_N <= 0;
        hold(5 * TK);
        SWITCH_WAKE_N <= 1;
        mode(1);
        pin_chk(7'h20, 7'h60);
        EN <= 1;
        mode(2);
        pin_chk(7'h40, 7'h60);
        $display("test transmit and switch wake done");
        host_txd <= 0;
        hold(3);
        EN <= 0;
        mode(4);
        host_txd <= 1;
        IGNITION_SENSE_INPUT <= 1;
        hold(5 * TK);
        mode(1);
        pin_chk(7'h20, 7'h20);
        mode(4);
        hold(10 * TK);
        avs(0, 4'h4, 0, 32'h4, 32'h7);
        IGNITION_SENSE_INPUT <= 0;
        hold(5 * TK);
        IGNITION_SENSE_INPUT <= 1;
        mode(1);
        EN <= 1;
        mode(2);
        $display("test ignition done");
        THERMAL_SHUTDOWN <= 1;
        host_txd <= 0;
        mode(1);
        pin_chk(7'h00, 7'h10);
        host_txd <= 1;
        THERMAL_SHUTDOWN <= 0;
        mode(2);
        WD_OK <= 0;
        hold(2);
        pin_chk(7'h02, 7'h0A);
        WD_OK <= 1;
        BATTERY_LOW <= 1;
        mode(0);
        pin_chk(7'h00, 7'h0C);
        AVS_BYTEENABLE <= 4'h0;
        avs(1, 4'h0, 32'h0, 0, 0);
        AVS_BYTEENABLE <= 4'hF;
        avs(0, 4'h0, 0, 32'h3, 32'h3);
        avs(1, 4'h0, 32'h0, 0, 0);
        BATTERY_LOW <= 0;
        mode(2);
        WD_OK <= 0;
        hold(2);
        pin_chk(7'h08, 7'h0A);
        WD_OK <= 1;
        EN <= 0;
        mode(3);
        SWITCH_WAKE_N <= 0;
        hold(5 * TK);
        SWITCH_WAKE_N <= 1;
        hold(2);
        avs(0, 4'h4, 0, 32'h3, 32'h7);
        host_txd <= 0;
        EN <= 1;
        mode(2);
        pin_chk(7'h01, 7'h01);
        $display("test thermal and supply done");
        give_verdict();
    end
endmodule
`default_nettype wire
